// [verilog/wwdg_core.sv]
`timescale 1ns/100ps
`include "wwdg_map.svh"

// ==========================================================================
module wwdg_core
    import wwdg_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic watchdog_caused_reset,
    input wire logic start_mode_select,
    input wire wwdg_pkg::wwdg_cfg_s boot_option_word,
    input wire logic cfg_write,
    input wire wwdg_pkg::wwdg_cfg_s cfg_wdata,
    input wire logic refresh_write,
    input wire logic [7:0] refresh_wdata,
    input wire logic status_write,
    input wire wwdg_pkg::wwdg_flags_s status_wdata,
    input wire logic low_power_state,
    output wwdg_pkg::wwdg_cfg_s cfg_active,
    output wwdg_pkg::wwdg_flags_s watchdog_status_reg,
    output logic [`WWDG_CNT_W-1:0] counter_value,
    output logic config_protect,
    output logic watchdog_reset_out,
    output logic watchdog_nmi_request
);
    import wwdg_pkg::*;

    // ======================================================================
    // Helpers
    function automatic logic [13:0] timeout_of(input logic [1:0] sel);
        case (sel)
            2'h0: timeout_of = `WWDG_TOP_0;
            2'h1: timeout_of = `WWDG_TOP_1;
            2'h2: timeout_of = `WWDG_TOP_2;
            default: timeout_of = `WWDG_TOP_3;
        endcase
    endfunction

    // Fraction of the timeout: 0 -> 75%, 1 -> 50%, 2 -> 25%, 3 -> 0%.
    function automatic logic [13:0] quarter_of(input logic [13:0] top,
                                                input logic [1:0] sel);
        logic [13:0] q;
        q = 14'(({1'b0, top} + 15'h0001) >> 2);
        case (sel)
            2'h0: quarter_of = 14'(q * 3);
            2'h1: quarter_of = 14'(q * 2);
            2'h2: quarter_of = q;
            default: quarter_of = 14'h0000;
        endcase
    endfunction

    function automatic logic [3:0] div_log2(input logic [3:0] sel);
        case (sel)
            4'h0: div_log2 = 4'h0;
            4'h2: div_log2 = 4'h4;
            4'h3: div_log2 = 4'h5;
            4'h4: div_log2 = 4'h6;
            4'h5: div_log2 = 4'h7;
            4'h6: div_log2 = 4'h8;
            default: div_log2 = 4'h9;
        endcase
    endfunction

    // ======================================================================
    // Configuration and protection
    wwdg_cfg_s cfg_reg;
    logic refresh_fire;

    // Settings survive a foreign reset together with the lock on them.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            if (watchdog_caused_reset) begin
                cfg_reg <= '0;
            end
        end else if (cfg_write && !config_protect) begin
            cfg_reg <= cfg_wdata;
        end
    end

    // The latch survives foreign resets, so it clears only on our own.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            if (watchdog_caused_reset) begin
                config_protect <= 1'b0;
            end
        end else if (cfg_write || refresh_fire) begin
            config_protect <= 1'b1;
        end
    end

    // Boot word is sampled live; the system must keep it stable.
    always_comb begin
        cfg_active = start_mode_select ? cfg_reg : boot_option_word;
    end

    // ======================================================================
    // Refresh key sequence
    logic armed;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            armed <= 1'b0;
        end else if (refresh_write) begin
            armed <= (refresh_wdata == `WWDG_KEY_ARM);
        end
    end

    assign refresh_fire = refresh_write && armed
        && (refresh_wdata == `WWDG_KEY_FIRE);

    // ======================================================================
    // Count clock divider
    logic [8:0] prescale;
    logic tick;
    logic [8:0] div_mask;

    assign div_mask = 9'((10'h001 << div_log2(
        cfg_active.clock_divide_select)) - 10'h001);
    assign tick = ((prescale & div_mask) == div_mask);

    always_ff @(posedge clock) begin
        if (!resetn) begin
            prescale <= 9'h000;
        end else begin
            prescale <= 9'(prescale + 9'h001);
        end
    end

    // ======================================================================
    // Counter and window
    wwdg_state_e state;
    logic [13:0] count;
    logic [13:0] top;
    logic [13:0] win_hi;
    logic [13:0] win_lo;
    logic in_window;
    logic pending;
    logic [2:0] reload_wait;
    logic fault;
    logic is_underflow;
    logic stopped;

    assign top = timeout_of(cfg_active.timeout_select);
    assign win_hi = quarter_of(top, cfg_active.window_start_select);
    assign win_lo = quarter_of(top, cfg_active.window_end_select);
    assign in_window = (count <= win_hi) && (count >= win_lo);
    assign stopped = cfg_active.sleep_count_stop && low_power_state;
    assign is_underflow = (state == WWDG_RUN) && tick && !stopped
        && (count == `WWDG_CNT_ZERO) && !pending;
    assign fault = is_underflow
        || (refresh_fire && state == WWDG_RUN && !in_window);

    always_ff @(posedge clock) begin
        if (!resetn) begin
            pending <= 1'b0;
            reload_wait <= 3'h0;
        end else if (refresh_fire && (state != WWDG_RUN || in_window)) begin
            pending <= 1'b1;
            reload_wait <= 3'h0;
        end else if (pending && tick) begin
            reload_wait <= 3'(reload_wait + 3'h1);
            if (reload_wait == 3'(`WWDG_RELOAD_CYCLES - 3'h1)) begin
                pending <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state <= start_mode_select ? WWDG_IDLE : WWDG_RUN;
            count <= `WWDG_CNT_ZERO;
        end else begin
            case (state)
                WWDG_IDLE: begin
                    if (pending && tick
                        && reload_wait == 3'(`WWDG_RELOAD_CYCLES - 3'h1)) begin
                        state <= WWDG_RUN;
                        count <= top;
                    end
                end
                WWDG_RUN: begin
                    if (fault) begin
                        state <= start_mode_select ? WWDG_HOLD
                                                   : WWDG_EXTRA;
                        count <= `WWDG_CNT_ZERO;
                    end else if (pending && tick && reload_wait
                        == 3'(`WWDG_RELOAD_CYCLES - 3'h1)) begin
                        count <= top;
                    end else if (tick && !stopped) begin
                        count <= 14'(count - 14'h0001);
                    end
                end
                WWDG_HOLD: begin
                    count <= `WWDG_CNT_ZERO;
                end
                WWDG_EXTRA: begin
                    if (tick) begin
                        state <= WWDG_RUN;
                        count <= top;
                    end
                end
                default: begin
                    state <= WWDG_IDLE;
                end
            endcase
        end
    end

    // ======================================================================
    // Response outputs
    always_ff @(posedge clock) begin
        if (!resetn) begin
            watchdog_reset_out <= 1'b0;
            watchdog_nmi_request <= 1'b0;
        end else begin
            watchdog_reset_out <= fault && cfg_active.reset_or_irq_select;
            watchdog_nmi_request <= fault
                && !cfg_active.reset_or_irq_select;
        end
    end

    // ======================================================================
    // Status flags: the set wins over a clear in the same cycle.
    // Flags live across any reset so software can read the cause.
    always_ff @(posedge clock) begin
        if (fault) begin
            watchdog_status_reg.underflow_flag <= is_underflow;
            watchdog_status_reg.refresh_error_flag <= !is_underflow;
        end else if (status_write) begin
            if (!status_wdata.underflow_flag) begin
                watchdog_status_reg.underflow_flag <= 1'b0;
            end
            if (!status_wdata.refresh_error_flag) begin
                watchdog_status_reg.refresh_error_flag <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Readback: a two-stage copy, so the value trails the count by two clock cycles.
    wwdg_sync #(
        .WIDTH(`WWDG_CNT_W)
    ) u_sync (
        .clock(clock),
        .resetn(resetn),
        .d(count),
        .q(counter_value)
    );

    // ======================================================================
    // Checks
    a_fault_response: assert property (
        @(posedge clock) disable iff (!resetn)
        fault |=> (watchdog_reset_out || watchdog_nmi_request))
        else $error("fault gave no response");
    a_nmi_select: assert property (
        @(posedge clock) disable iff (!resetn)
        watchdog_nmi_request |-> !watchdog_reset_out)
        else $error("nmi and reset together");
    a_protect_sets: assert property (
        @(posedge clock) disable iff (!resetn)
        cfg_write |=> config_protect)
        else $error("protect did not set");
    a_cfg_frozen: assert property (
        @(posedge clock) disable iff (!resetn)
        config_protect |=> $stable(cfg_reg))
        else $error("protected config changed");
    a_bad_key: assert property (
        @(posedge clock) disable iff (!resetn)
        (refresh_write && refresh_wdata != `WWDG_KEY_FIRE)
        |-> !refresh_fire)
        else $error("refresh on wrong key");
    a_flag_clear: assert property (
        @(posedge clock) disable iff (!resetn)
        (status_write && !status_wdata.underflow_flag && !fault)
        |=> !watchdog_status_reg.underflow_flag)
        else $error("flag clear lost");
    a_hold_zero: assert property (
        @(posedge clock) disable iff (!resetn)
        (state == WWDG_HOLD) |=> count == `WWDG_CNT_ZERO)
        else $error("held counter not zero");
    a_sync_lag: assert property (
        @(posedge clock) disable iff (!resetn)
        ##2 counter_value == $past(count, 2))
        else $error("readback lag wrong");
    a_window_error: assert property (
        @(posedge clock) disable iff (!resetn)
        (refresh_fire && state == WWDG_RUN && !in_window)
        |=> watchdog_status_reg.refresh_error_flag)
        else $error("window error not flagged");
    a_idle_still: assert property (
        @(posedge clock) disable iff (!resetn)
        (state == WWDG_IDLE && !pending) |=> count == `WWDG_CNT_ZERO)
        else $error("idle counter moved");
    a_extra_reload: assert property (
        @(posedge clock) disable iff (!resetn)
        (state == WWDG_EXTRA && tick) |=> (count == $past(top)))
        else $error("extra cycle did not reload");
    a_sleep_stop: assert property (
        @(posedge clock) disable iff (!resetn)
        (state == WWDG_RUN && stopped && !fault && !pending)
        |=> $stable(count))
        else $error("counter moved while stopped");
    a_protect_kept: assert property (
        @(posedge clock) disable iff (!resetn)
        config_protect |=> config_protect)
        else $error("protect dropped outside reset");
    a_flag_replace: assert property (
        @(posedge clock) disable iff (!resetn)
        (fault && is_underflow)
        |=> (watchdog_status_reg == 2'b01))
        else $error("underflow cause not recorded");
    c_refresh: cover property (@(posedge clock) refresh_fire);
    c_underflow: cover property (@(posedge clock) is_underflow);
    c_window_err: cover property (@(posedge clock) fault && !is_underflow);
    c_auto_extra: cover property (@(posedge clock) state == WWDG_EXTRA);
    c_sleep: cover property (@(posedge clock) stopped && state == WWDG_RUN);
endmodule

// [verilog/wwdg_map.svh]
`ifndef WWDG_MAP_SVH
`define WWDG_MAP_SVH

// ==========================================================================
// Refresh key values
`define WWDG_KEY_ARM 8'h00
`define WWDG_KEY_FIRE 8'hff

// ==========================================================================
// Counter and timing
`define WWDG_CNT_W 14
`define WWDG_CNT_ZERO 14'h0000
`define WWDG_RELOAD_CYCLES 3'h4
`define WWDG_CLEAR_LAT 3'h3

// ==========================================================================
// Timeout encodings, counts minus one
`define WWDG_TOP_0 14'h03ff
`define WWDG_TOP_1 14'h0fff
`define WWDG_TOP_2 14'h1fff
`define WWDG_TOP_3 14'h3fff

`endif

// [verilog/wwdg_pkg.sv]
package wwdg_pkg;

    typedef struct packed {
        logic [3:0] clock_divide_select;
        logic [1:0] timeout_select;
        logic [1:0] window_start_select;
        logic [1:0] window_end_select;
        logic reset_or_irq_select;
        logic sleep_count_stop;
    } wwdg_cfg_s;

    typedef struct packed {
        logic refresh_error_flag;
        logic underflow_flag;
    } wwdg_flags_s;

    typedef enum logic [1:0] {
        WWDG_IDLE,
        WWDG_RUN,
        WWDG_HOLD,
        WWDG_EXTRA
    } wwdg_state_e;

endpackage

// [verilog/wwdg_sync.sv]
`timescale 1ns/100ps

// ==========================================================================
// Two-stage level synchroniser for a word that changes slowly.
module wwdg_sync #(
    parameter int WIDTH = 14
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            stage1 <= '0;
            q <= '0;
        end else begin
            stage1 <= d;
            q <= stage1;
        end
    end
endmodule

// [sim/testbench.sv]
`timescale 1ns/100ps

module testbench;
    import wwdg_pkg::*;

    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic watchdog_caused_reset = 1'b1;
    logic start_mode_select = 1'b1;
    wwdg_cfg_s boot_option_word = '0;
    logic cfg_write = 1'b0;
    wwdg_cfg_s cfg_wdata = '0;
    logic refresh_write = 1'b0;
    logic [7:0] refresh_wdata = 8'h00;
    logic status_write = 1'b0;
    wwdg_flags_s status_wdata = '0;
    logic low_power_state = 1'b0;
    wwdg_cfg_s cfg_active;
    wwdg_flags_s watchdog_status_reg;
    logic [13:0] counter_value;
    logic config_protect;
    logic watchdog_reset_out;
    logic watchdog_nmi_request;
    int bad_count = 0;
    int num_checks = 0;

    // ======================================================================
    // Clock and device under test
    always #50 clock = ~clock;

    wwdg_core dut (
        .clock(clock),
        .resetn(resetn),
        .watchdog_caused_reset(watchdog_caused_reset),
        .start_mode_select(start_mode_select),
        .boot_option_word(boot_option_word),
        .cfg_write(cfg_write),
        .cfg_wdata(cfg_wdata),
        .refresh_write(refresh_write),
        .refresh_wdata(refresh_wdata),
        .status_write(status_write),
        .status_wdata(status_wdata),
        .low_power_state(low_power_state),
        .cfg_active(cfg_active),
        .watchdog_status_reg(watchdog_status_reg),
        .counter_value(counter_value),
        .config_protect(config_protect),
        .watchdog_reset_out(watchdog_reset_out),
        .watchdog_nmi_request(watchdog_nmi_request)
    );

    // ======================================================================
    // Shared tasks
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("Checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clock);
    endtask

    // Each reset is held for eight cycles so that every path settles.
    task automatic do_reset(input logic caused, input logic mode);
        @(negedge clock);
        resetn = 1'b0;
        watchdog_caused_reset = caused;
        start_mode_select = mode;
        cycles(8);
        resetn = 1'b1;
        watchdog_caused_reset = 1'b0;
    endtask

    task automatic refresh(input logic [7:0] v);
        @(negedge clock);
        refresh_write = 1'b1;
        refresh_wdata = v;
        @(negedge clock);
        refresh_write = 1'b0;
    endtask

    task automatic write_cfg(input wwdg_cfg_s c);
        @(negedge clock);
        cfg_write = 1'b1;
        cfg_wdata = c;
        @(negedge clock);
        cfg_write = 1'b0;
    endtask

    task automatic write_status(input logic [1:0] v);
        @(negedge clock);
        status_write = 1'b1;
        status_wdata = v;
        @(negedge clock);
        status_write = 1'b0;
    endtask

    // A pulse stands one cycle, so it is looked for once in every cycle.
    task automatic wait_pulse(input string what, input int limit,
                              input logic want_nmi);
        int i;
        for (i = 0; i < limit; i++) begin
            if ((want_nmi ? watchdog_nmi_request : watchdog_reset_out)
                === 1'b1) break;
            @(negedge clock);
        end
        check(what, 16'(i < limit), 16'h1);
    endtask

    task automatic check_running(input string what);
        check(what, 16'(counter_value > 14'h03e0 &&
                        counter_value <= 14'h03ff), 16'h1);
    endtask

    // ======================================================================
    // Scenarios
    task automatic test_protect_and_refresh();
        wwdg_cfg_s a;
        a = '{4'h0, 2'h0, 2'h0, 2'h3, 1'b1, 1'b0};
        do_reset(1'b1, 1'b1);
        check("protect_idle", 16'(config_protect), 16'h0);
        write_cfg(a);
        check("cfg_taken", 16'(cfg_active), 16'(a));
        check("protect_set", 16'(config_protect), 16'h1);
        write_cfg('{4'h6, 2'h3, 2'h1, 2'h1, 1'b0, 1'b1});
        check("cfg_refused", 16'(cfg_active), 16'(a));
        refresh(8'h00);
        refresh(8'h54);
        refresh(8'h23);
        refresh(8'hff);
        cycles(10);
        check("no_start", 16'(counter_value), 16'h0);
        refresh(8'h00);
        refresh(8'h00);
        refresh(8'hff);
        cycles(12);
        check_running("started");
        $display("Test protect_and_refresh done");
    endtask

    task automatic test_underflow_reset();
        wait_pulse("reset_out", 1100, 1'b0);
        cycles(5);
        check("held_zero", 16'(counter_value), 16'h0);
        check("underflow", 16'(watchdog_status_reg.underflow_flag),
              16'h1);
        $display("Test underflow_reset done");
    endtask

    task automatic test_window_nmi();
        wwdg_cfg_s b;
        b = '{4'h0, 2'h0, 2'h0, 2'h3, 1'b0, 1'b0};
        do_reset(1'b1, 1'b1);
        check("protect_freed", 16'(config_protect), 16'h0);
        write_cfg(b);
        do_reset(1'b0, 1'b1);
        check("protect_kept", 16'(config_protect), 16'h1);
        check("cfg_kept", 16'(cfg_active), 16'(b));
        refresh(8'h00);
        refresh(8'hff);
        cycles(10);
        // Near the top the count is above the 75 percent window start.
        refresh(8'h00);
        refresh(8'hff);
        wait_pulse("nmi", 20, 1'b1);
        cycles(2);
        check("err_cause", 16'(watchdog_status_reg), 16'h2);
        write_status(2'b10);
        cycles(3);
        check("one_kept", 16'(watchdog_status_reg), 16'h2);
        write_status(2'b01);
        cycles(3);
        check("cleared", 16'(watchdog_status_reg), 16'h0);
        $display("Test window_nmi done");
    endtask

    task automatic test_sleep_stop();
        logic [13:0] held;
        do_reset(1'b1, 1'b1);
        write_cfg('{4'h0, 2'h0, 2'h3, 2'h3, 1'b1, 1'b1});
        refresh(8'h00);
        refresh(8'hff);
        cycles(8);
        low_power_state = 1'b1;
        cycles(3);
        held = counter_value;
        cycles(4);
        check("sleep_held", 16'(counter_value), 16'(held));
        low_power_state = 1'b0;
        cycles(4);
        check("sleep_resumed", 16'(counter_value < held), 16'h1);
        $display("Test sleep_stop done");
    endtask

    task automatic test_auto_start();
        // Set before the reset starts, while start mode 1 still selects the stored settings.
        boot_option_word = '{4'h0, 2'h0, 2'h3, 2'h3, 1'b1, 1'b0};
        do_reset(1'b1, 1'b0);
        check("boot_cfg", 16'(cfg_active),
              16'(boot_option_word));
        wait_pulse("auto_reset", 20, 1'b0);
        cycles(10);
        check_running("auto_resume");
        check("auto_cause", 16'(watchdog_status_reg), 16'h1);
        $display("Test auto_start done");
    endtask

    // ======================================================================
    // Main sequence and watchdog
    initial begin
        test_protect_and_refresh();
        test_underflow_reset();
        test_window_nmi();
        test_sleep_stop();
        test_auto_start();
        results();
    end

    initial begin
        #(100 * 20000);
        bad_count++;
        results();
    end
endmodule
